// File: fpcd_regs.vh
// Register map, field positions, opcodes and reset values of the command decoder
`ifndef FPCD_REGS_VH
`define FPCD_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPCD_CMD_OFF 12'h000
`define FPCD_DEC_OFF 12'h004
`define FPCD_SEL_OFF 12'h008
`define FPCD_STAT_OFF 12'h00C
`define FPCD_DHR_OFF 12'h010
`define FPCD_OPA_OFF 12'h014
`define FPCD_RES_OFF 12'h018
// ----------------------------------------
// Command word fields
// ----------------------------------------
`define FPCD_ID_HI 31
`define FPCD_ID_LO 24
`define FPCD_OPC_HI 14
`define FPCD_OPC_LO 10
`define FPCD_S1_HI 9
`define FPCD_S1_LO 7
`define FPCD_S2_HI 6
`define FPCD_S2_LO 4
`define FPCD_DST_HI 3
`define FPCD_DST_LO 0
// ----------------------------------------
// Condition flag positions in the status register
// ----------------------------------------
`define FPCD_F_UNORD 0
`define FPCD_F_PREM 1
`define FPCD_F_IO 2
`define FPCD_F_Z 3
`define FPCD_F_N 4
`define FPCD_FLAG_MASK 32'h0000001F
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define FPCD_OP_ADD 5'h02
`define FPCD_OP_SUB 5'h03
`define FPCD_OP_DIV 5'h04
`define FPCD_OP_REM 5'h05
`define FPCD_OP_MUL 5'h06
`define FPCD_OP_MOVE 5'h07
`define FPCD_OP_RDST 5'h08
`define FPCD_OP_WRST 5'h09
`define FPCD_OP_CMP 5'h0A
`define FPCD_OP_CMPR 5'h0B
`define FPCD_OP_ABS 5'h0C
`define FPCD_OP_SQRT 5'h0D
`define FPCD_OP_RINT 5'h0E
`define FPCD_OP_F2I 5'h0F
`define FPCD_OP_I2F 5'h10
`define FPCD_OP_D2F 5'h11
`define FPCD_OP_F2D 5'h12
`define FPCD_OP_ABORT 5'h13
`define FPCD_OP_FEXT 5'h14
`define FPCD_OP_NEG 5'h17
`define FPCD_OP_HLD 5'h18
`define FPCD_OP_CMPSW 5'h1A
`define FPCD_OP_CMPRS 5'h1B
`define FPCD_OP_SIN 5'h1C
`define FPCD_OP_COS 5'h1D
`define FPCD_OP_ARCTAN 5'h1E
`define FPCD_OP_PI 5'h1F
// ----------------------------------------
// Constants and reset values
// ----------------------------------------
`define FPCD_PI_SGL 32'h40490FDB
`define FPCD_RST_WORD 32'h00000000
`define FPCD_RST_SEL 32'h00000000
`endif

// File: fpcd_decode.v
// Command word decoder and operation dispatcher with APB register access
`timescale 1ns/1ps
// Summary of operation
// - 0x02 adds, 0x03 subtracts operand one from two
// - 0x04 divides operand two by operand one
// - 0x05 gives IEEE remainder of the division
// - 0x06 multiplies operands one and two
// - Move, clear-sign, invert-sign copies of operand one
// - 0x0A/0x0B compare, set flags, store nothing
// - 0x1A/0x1B compare with flags swapped
// - Float to integer and integer to float
// - Decimal to float; round then float to decimal
// - 0x0E rounds to integral, stays float
// - Sine, cosine, arctangent of operand one
// - 0x1F stores constant pi
// - 0x13 aborts running operation, flags unchanged
// - 0x14 returns holding register at any time, fault or not
// - 0x18 loads holding register from operand one
// - 0x08 reads status, 0x09 writes status
// - Which operations update the five condition flags
// - Latch broadcast command only on identity match
// - Operand specifiers from bits 9-7, 6-4, 3-0
// - Quiescent: only bus accesses, no register activity
// - Unassigned opcodes behave like abort
`include "fpcd_regs.vh"

module fpcd_decode #(
  parameter [7:0] OWN_ID = 8'h5A // Identity number, value arbitrary
) (
  input wire pclk, // Bus and device clock
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire dp_done, // Datapath finished the started operation
  input wire [4:0] dp_flags, // Datapath flags: negative down to unordered
  input wire [31:0] dp_result, // Datapath result word
  output reg [31:0] op_sel, // One-hot operation select
  output reg flag_upd, // Decoded operation updates flags
  output reg flag_swap, // Compare reports swapped flags
  output reg [2:0] src1_spec, // First source specifier
  output reg [2:0] src2_spec, // Second source specifier
  output reg [3:0] dst_spec, // Destination specifier
  output reg dp_start, // One-cycle start to datapath
  output reg dp_abort, // One-cycle abort to datapath
  output reg busy // High while an operation runs
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Opcode carries an instruction
  function is_assigned;
    input [4:0] opc;
    begin
      is_assigned = !(opc == 5'h00 || opc == 5'h01 || opc == 5'h15 ||
                      opc == 5'h16 || opc == 5'h19);
    end
  endfunction

  // Unassigned codes fold onto abort
  function [4:0] fold_op;
    input [4:0] opc;
    begin
      fold_op = is_assigned(opc) ? opc : `FPCD_OP_ABORT;
    end
  endfunction

  // Flag update per folded opcode
  function upd_of;
    input [4:0] opc;
    begin
      case (opc)
        `FPCD_OP_RDST: upd_of = 1'b0;
        `FPCD_OP_ABORT: upd_of = 1'b0;
        `FPCD_OP_FEXT: upd_of = 1'b0;
        `FPCD_OP_HLD: upd_of = 1'b0;
        default: upd_of = 1'b1;
      endcase
    end
  endfunction

  // Operation runs in the arithmetic datapath
  function is_dp;
    input [4:0] opc;
    begin
      case (opc)
        `FPCD_OP_ADD, `FPCD_OP_SUB: is_dp = 1'b1;
        `FPCD_OP_DIV: is_dp = 1'b1;
        `FPCD_OP_REM: is_dp = 1'b1;
        `FPCD_OP_MUL: is_dp = 1'b1;
        `FPCD_OP_CMP, `FPCD_OP_CMPR: is_dp = 1'b1;
        `FPCD_OP_CMPSW, `FPCD_OP_CMPRS: is_dp = 1'b1;
        `FPCD_OP_F2I, `FPCD_OP_I2F: is_dp = 1'b1;
        `FPCD_OP_D2F, `FPCD_OP_F2D: is_dp = 1'b1;
        `FPCD_OP_RINT: is_dp = 1'b1;
        `FPCD_OP_SIN, `FPCD_OP_COS: is_dp = 1'b1;
        `FPCD_OP_ARCTAN, `FPCD_OP_SQRT: is_dp = 1'b1;
        default: is_dp = 1'b0;
      endcase
    end
  endfunction

  // Compare stores no result
  function is_cmp;
    input [4:0] opc;
    begin
      is_cmp = (opc == `FPCD_OP_CMP) || (opc == `FPCD_OP_CMPR) ||
               (opc == `FPCD_OP_CMPSW) || (opc == `FPCD_OP_CMPRS);
    end
  endfunction

  // Flags of a single word copied value
  function [4:0] word_flags;
    input [31:0] w;
    begin
      word_flags = {w[31], (w[30:0] == 31'h00000000), 3'b000};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] command_word_reg; // Latched command word
  reg [31:0] aux_status_reg; // Auxiliary status register
  reg [31:0] data_holding_reg; // Holding register
  reg [31:0] operand_reg; // First operand word
  reg [31:0] result_reg; // Third operand word
  reg cmd_new_reg; // Command waiting to be decoded
  reg [4:0] run_op_reg; // Operation held by the datapath
  reg [31:0] rd_next; // Read mux
  reg rd_err_next; // Unmapped address
  reg [4:0] opc_next; // Folded opcode of latched word
  reg [4:0] new_flags; // Flags of an internal operation

  wire setup_ph = psel && !penable; // APB setup cycle
  wire wr_take = psel && penable && pready && pwrite; // Write effect edge
  wire cmd_wr = wr_take && (paddr == `FPCD_CMD_OFF); // Broadcast transfer
  wire id_hit = (pwdata[`FPCD_ID_HI:`FPCD_ID_LO] == OWN_ID);
  wire stat_wr = wr_take && (paddr == `FPCD_STAT_OFF); // Direct status write
  wire opa_wr = wr_take && (paddr == `FPCD_OPA_OFF); // Operand load

  // ----------------------------------------
  // APB read mux and address check
  // ----------------------------------------
  // Reads have no side effects; status fetch is a plain read of 0x0C
  always @* begin
    rd_next = `FPCD_RST_WORD;
    rd_err_next = 1'b0;
    case (paddr)
      `FPCD_CMD_OFF: rd_next = command_word_reg;
      `FPCD_DEC_OFF: rd_next = {14'h0000, busy, flag_upd, flag_swap,
                                run_op_reg, src1_spec, src2_spec, dst_spec};
      `FPCD_SEL_OFF: rd_next = op_sel;
      `FPCD_STAT_OFF: rd_next = aux_status_reg;
      `FPCD_DHR_OFF: rd_next = data_holding_reg;
      `FPCD_OPA_OFF: rd_next = operand_reg;
      `FPCD_RES_OFF: rd_next = result_reg;
      default: rd_err_next = 1'b1; // Unmapped: zero data, error
    endcase
  end

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait-free access; data and ready are registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `FPCD_RST_WORD;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        pslverr <= rd_err_next;
        prdata <= pwrite ? `FPCD_RST_WORD : rd_next;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Command latch
  // ----------------------------------------
  // A word for another processor leaves the register untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_word_reg <= `FPCD_RST_WORD;
      cmd_new_reg <= 1'b0;
    end else begin
      cmd_new_reg <= cmd_wr && id_hit;
      if (cmd_wr && id_hit) begin
        command_word_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Operand load
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_reg <= `FPCD_RST_WORD;
    end else if (opa_wr) begin
      operand_reg <= pwdata;
    end
  end

  // ----------------------------------------
  // Decode of the latched word
  // ----------------------------------------
  always @* begin
    opc_next = fold_op(command_word_reg[`FPCD_OPC_HI:`FPCD_OPC_LO]);
  end

  // Select, specifiers and flag enable follow the latch by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_sel <= `FPCD_RST_SEL;
      flag_upd <= 1'b0;
      flag_swap <= 1'b0;
      src1_spec <= 3'h0;
      src2_spec <= 3'h0;
      dst_spec <= 4'h0;
      run_op_reg <= 5'h00;
    end else if (cmd_new_reg) begin
      op_sel <= 32'h00000001 << opc_next;
      flag_upd <= upd_of(opc_next);
      flag_swap <= (opc_next == `FPCD_OP_CMPSW) ||
                   (opc_next == `FPCD_OP_CMPRS);
      src1_spec <= command_word_reg[`FPCD_S1_HI:`FPCD_S1_LO];
      src2_spec <= command_word_reg[`FPCD_S2_HI:`FPCD_S2_LO];
      dst_spec <= command_word_reg[`FPCD_DST_HI:`FPCD_DST_LO];
      run_op_reg <= opc_next;
    end
  end

  // ----------------------------------------
  // Dispatch and completion
  // ----------------------------------------
  // Quiescent means busy low and no command pending: no start, and only bus writes update registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      dp_start <= 1'b0;
      dp_abort <= 1'b0;
    end else begin
      dp_start <= 1'b0;
      dp_abort <= 1'b0;
      if (cmd_new_reg) begin
        if (opc_next == `FPCD_OP_ABORT) begin
          dp_abort <= busy;
          busy <= 1'b0;
        end else if (is_dp(opc_next)) begin
          dp_abort <= busy; // New command cuts the old one short
          dp_start <= 1'b1;
          busy <= 1'b1;
        end else begin
          dp_abort <= busy;
          busy <= 1'b0;
        end
      end else if (busy && dp_done) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Internal single-word operations
  // ----------------------------------------
  // Flags for the copies computed inside the decoder
  always @* begin
    new_flags = 5'h00;
    case (opc_next)
      `FPCD_OP_MOVE: new_flags = word_flags(operand_reg);
      `FPCD_OP_ABS: new_flags = word_flags({1'b0, operand_reg[30:0]});
      `FPCD_OP_NEG: new_flags = word_flags({~operand_reg[31], operand_reg[30:0]});
      `FPCD_OP_WRST: new_flags = operand_reg[4:0];
      default: new_flags = 5'h00; // Pi gives all flags cleared
    endcase
  end

  // Result, holding and status registers; touched by a command, a datapath completion or a direct status write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= `FPCD_RST_WORD;
      data_holding_reg <= `FPCD_RST_WORD;
      aux_status_reg <= `FPCD_RST_WORD;
    end else if (cmd_new_reg) begin
      case (opc_next)
        `FPCD_OP_MOVE: begin
          result_reg <= operand_reg;
          aux_status_reg[4:0] <= new_flags;
        end
        `FPCD_OP_ABS: begin
          result_reg <= {1'b0, operand_reg[30:0]};
          aux_status_reg[4:0] <= new_flags;
        end
        `FPCD_OP_NEG: begin
          result_reg <= {~operand_reg[31], operand_reg[30:0]};
          aux_status_reg[4:0] <= new_flags;
        end
        `FPCD_OP_PI: begin
          result_reg <= `FPCD_PI_SGL;
          aux_status_reg[4:0] <= new_flags;
        end
        `FPCD_OP_RDST: begin
          result_reg <= aux_status_reg;
        end
        `FPCD_OP_WRST: begin
          aux_status_reg <= operand_reg;
        end
        `FPCD_OP_FEXT: begin
          result_reg <= data_holding_reg;
        end
        `FPCD_OP_HLD: begin
          data_holding_reg <= operand_reg;
        end
        default: begin
          result_reg <= result_reg;
        end
      endcase
    end else if (busy && dp_done) begin
      if (!is_cmp(run_op_reg)) begin
        result_reg <= dp_result;
      end
      if (flag_upd) begin
        aux_status_reg[4:0] <= dp_flags;
      end
    end else if (stat_wr) begin
      aux_status_reg <= pwdata; // Direct status write when no command or completion is taken this cycle
    end
  end

endmodule // fpcd_decode

// File: fpcd_dp_model.sv
// Behavioural datapath model facing the decoder's dispatch outputs
`timescale 1ns/1ps
module fpcd_dp_model #(
  parameter int DELAY = 8, // Cycles from start to done
  parameter [31:0] RES = 32'h3F800000, // Result word handed back
  parameter [4:0] FLG = 5'h0A // Flags handed back, negative down to unordered
) (
  input wire pclk, // Device clock
  input wire presetn, // Asynchronous reset, active low
  input wire dp_start, // Operation begins
  input wire dp_abort, // Operation cut short
  output logic dp_done, // One-cycle completion pulse
  output wire [4:0] dp_flags, // Final flags, valid with done
  output wire [31:0] dp_result // Result word, valid with done
);
  // ----------------------------------------
  // Operation timer
  // ----------------------------------------
  int cnt; // Cycles left, zero when idle
  // Restart wins over abort, so a new command while busy runs to completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      dp_done <= 1'b0;
    end else begin
      // A restart or abort on the last cycle must not end the new operation early
      dp_done <= (cnt == 1) && !dp_start && !dp_abort;
      if (dp_start) begin
        cnt <= DELAY;
      end else if (dp_abort) begin
        cnt <= 0;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Outside the done pulse the lines carry the inverse, never a stale match
  assign dp_result = dp_done ? RES : ~RES;
  assign dp_flags = dp_done ? FLG : ~FLG;
endmodule // fpcd_dp_model

// File: fpcd_decode_asserts.sv
// Port-level concurrent checks for the command decoder
`timescale 1ns/1ps
`include "fpcd_regs.vh"
module fpcd_decode_asserts #(
  parameter [7:0] OWN_ID = 8'h5A // Identity number, value arbitrary
) (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB address
  input wire [31:0] pwdata, // APB write data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire dp_done, // Datapath done
  input wire [31:0] op_sel, // One-hot select
  input wire flag_upd, // Flag update enable
  input wire flag_swap, // Swapped flags
  input wire [2:0] src1_spec, // First source
  input wire [2:0] src2_spec, // Second source
  input wire [3:0] dst_spec, // Destination
  input wire dp_start, // Start pulse
  input wire dp_abort, // Abort pulse
  input wire busy // Operation running
);
  // ----------------------------------------
  // Last command taken on the bus
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hit_q; // Matching command taken last edge
  logic miss_q; // Foreign command taken last edge
  logic [14:0] w_q; // Opcode and specifier bits
  wire cmd_w = psel && penable && pready && pwrite && (paddr == `FPCD_CMD_OFF);
  wire hit_w = cmd_w && (pwdata[31:24] == OWN_ID);
  function automatic [4:0] fold(input [4:0] o);
    case (o)
      5'h00, 5'h01, 5'h15, 5'h16, 5'h19: fold = 5'h13; // Unassigned act as abort
      default: fold = o;
    endcase
  endfunction
  wire [4:0] f_q = fold(w_q[14:10]);
  // Word kept from the last matching command; outputs follow it one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q <= 1'b0;
      miss_q <= 1'b0;
      w_q <= 15'h0000;
    end else begin
      hit_q <= hit_w;
      miss_q <= cmd_w && !hit_w;
      if (hit_w) begin
        w_q <= pwdata[14:0];
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("access phase without ready");
  sel_fold_a: assert property (hit_q |=> op_sel == (32'h1 << f_q))
    else $error("operation select wrong");
  spec_field_a: assert property (hit_q |=> {src1_spec, src2_spec, dst_spec} == w_q[9:0])
    else $error("operand specifiers wrong");
  flag_upd_a: assert property (hit_q |=> flag_upd == !(f_q inside {5'h08, 5'h13, 5'h14, 5'h18}))
    else $error("flag update enable wrong");
  swap_sel_a: assert property (hit_q |=> flag_swap == (f_q[4:1] == 4'hD))
    else $error("flag swap wrong");
  id_miss_a: assert property (miss_q |=> $stable(op_sel) && !dp_start)
    else $error("foreign command acted on");
  quiet_start_a: assert property (dp_start |-> $past(hit_q))
    else $error("start without command");
  abort_cut_a: assert property (busy && !dp_done && hit_w |-> ##2 dp_abort)
    else $error("running operation not cut");
  nop_idle_a: assert property (hit_q && f_q == 5'h13 |=> !busy && !dp_start)
    else $error("abort left work running");
endmodule // fpcd_decode_asserts
bind fpcd_decode fpcd_decode_asserts #(.OWN_ID(OWN_ID)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .dp_done(dp_done), .op_sel(op_sel),
  .flag_upd(flag_upd), .flag_swap(flag_swap), .src1_spec(src1_spec), .src2_spec(src2_spec),
  .dst_spec(dst_spec), .dp_start(dp_start), .dp_abort(dp_abort), .busy(busy));

// File: tb_top.sv
// Self-checking bench for the command decoder over APB
`timescale 1ns/1ps
`include "fpcd_regs.vh"
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam [7:0] ID = 8'h5A; // Decoder default identity
  localparam [31:0] MR = 32'h3F800000; // Model result word
  logic pclk = 1'b0; // Clock
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata, op_sel, dp_result;
  wire pready, pslverr, dp_done, flag_upd, flag_swap, dp_start, dp_abort, busy;
  wire [4:0] dp_flags;
  wire [2:0] src1_spec, src2_spec;
  wire [3:0] dst_spec;
  int failures = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  int i;
  logic [31:0] rd; // Last read data
  logic er; // Last error response
  // Op table, internal ops then compare and divide: operand, opcode, result, status
  logic [31:0] t_opa [11] = '{32'h80000005, 32'h80000005, 32'h0, 32'h1F, 32'h1F,
    32'h12345678, 32'h12345678, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [4:0] t_op [11] = '{5'h07, 5'h0C, 5'h17, 5'h09, 5'h08, 5'h18, 5'h14, 5'h13,
    5'h1F, 5'h0A, 5'h04};
  logic [31:0] t_res [11] = '{32'h80000005, 32'h5, 32'h80000000, 32'h80000000, 32'h1F,
    32'h1F, 32'h12345678, 32'h12345678, 32'h40490FDB, 32'h40490FDB, MR};
  logic [31:0] t_asr [11] = '{32'h10, 32'h0, 32'h18, 32'h1F, 32'h1F, 32'h1F, 32'h1F,
    32'h1F, 32'h0, 32'h0A, 32'h0A};
  always #12.5 pclk = ~pclk;
  fpcd_decode u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dp_done(dp_done), .dp_flags(dp_flags), .dp_result(dp_result),
    .op_sel(op_sel), .flag_upd(flag_upd), .flag_swap(flag_swap), .src1_spec(src1_spec),
    .src2_spec(src2_spec), .dst_spec(dst_spec), .dp_start(dp_start), .dp_abort(dp_abort),
    .busy(busy));
  fpcd_dp_model u_dp (.pclk(pclk), .presetn(presetn), .dp_start(dp_start),
    .dp_abort(dp_abort), .dp_done(dp_done), .dp_flags(dp_flags), .dp_result(dp_result));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic [4:0] fold(input [4:0] o);
    fold = (o inside {5'h00, 5'h01, 5'h15, 5'h16, 5'h19}) ? 5'h13 : o;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; an edge passes first so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Command write, then let the decoded outputs land
  task automatic cmd(input [4:0] o, input [7:0] id, input [9:0] sp);
    apb(1'b1, `FPCD_CMD_OFF, {id, 9'h000, o, sp});
    @(posedge pclk);
    #1;
  endtask
  // Bounded wait for the datapath to finish
  task automatic idle();
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge pclk);
    #1;
    chk("busy", {31'h0, busy}, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FPCD_SEL_OFF, 32'h0);
    chk("sel_rst", rd, `FPCD_RST_SEL);
    for (i = 0; i < 32; i++) begin
      cmd(i[4:0], ID, {i[2:0], ~i[2:0], i[3:0]});
      chk("op_sel", op_sel, 32'h1 << fold(i[4:0]));
      chk("upd", {31'h0, flag_upd}, {31'h0, !(fold(i[4:0]) inside {8, 19, 20, 24})});
      chk("swap", {31'h0, flag_swap}, {31'h0, i[4:1] == 4'hD});
      chk("spec", {22'h0, src1_spec, src2_spec, dst_spec}, {22'h0, i[2:0], ~i[2:0], i[3:0]});
      idle();
    end
    cmd(5'h02, 8'hA5, 10'h0);
    chk("foreign", op_sel, 32'h80000000);
    for (i = 0; i < 11; i++) begin
      apb(1'b1, `FPCD_OPA_OFF, t_opa[i]);
      cmd(t_op[i], ID, 10'h0);
      idle();
      apb(1'b0, `FPCD_RES_OFF, 32'h0);
      chk("result", rd, t_res[i]);
      apb(1'b0, `FPCD_STAT_OFF, 32'h0);
      chk("status", rd, t_asr[i]);
    end
    apb(1'b1, `FPCD_STAT_OFF, 32'h15);
    cmd(5'h02, ID, 10'h0);
    chk("busy_add", {31'h0, busy}, 32'h1);
    cmd(5'h13, ID, 10'h0);
    chk("busy_nop", {31'h0, busy}, 32'h0);
    repeat (12) @(posedge pclk);
    apb(1'b0, `FPCD_STAT_OFF, 32'h0);
    chk("stat_kept", rd, 32'h15);
    apb(1'b0, `FPCD_DEC_OFF, 32'h0);
    chk("dec_word", rd, 32'h00004C00);
    apb(1'b0, `FPCD_RES_OFF, 32'h0);
    chk("res_kept", rd, MR);
    apb(1'b1, `FPCD_SEL_OFF, 32'hFFFFFFFF);
    apb(1'b0, `FPCD_SEL_OFF, 32'h0);
    chk("sel_ro", rd, 32'h00080000);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
